// ===== design/eeprom_params.svh
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH

// =====================================================
// array geometry
`define ADDR_W 11
`define PAGE_W 4
`define PAGE_BYTES 16
`define MEM_BYTES 2048

// =====================================================
// serial framing
`define DEV_PATTERN 4'hA
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
`define BIT_SECOND 4'h1

// =====================================================
// timing
`define CLK_PERIOD_NS 8
`define PROG_TIME_NS 3000000
`define PROG_CYCLES (`PROG_TIME_NS / `CLK_PERIOD_NS)
`define PROG_CNT_W 19
`define RS_PULSE_CYCLES 2'h3

`endif

// ===== design/eeprom_types_pkg.sv
`include "eeprom_params.svh"

package eeprom_types_pkg;

  // =====================================================
  // link-side protocol states
  typedef enum logic [4:0] {
    ST_DEV = 5'h01,
    ST_WADDR = 5'h02,
    ST_WDATA = 5'h04,
    ST_RDATA = 5'h08,
    ST_IGNORE = 5'h10
  } link_state_type;

  // =====================================================
  // device address word layout
  typedef struct packed {
    logic [3:0] pattern;
    logic [2:0] blk;
    logic rd;
  } dev_word_type;

  // signals brought into the system clock domain
  typedef struct packed {
    logic pend;
    logic wp;
    logic sda;
    logic scl;
  } sync_type;

endpackage

// ===== design/i2c_serial_eeprom_slave.sv
// Function
// - 2048 bytes as 128 pages of 16, 11-bit word address.
// - sample SDA on SCL rise, change driven SDA after SCL fall.
// - SDA changes with SCL high are start or stop only.
// - falling SDA with SCL high is start; decoding begins after it.
// - rising SDA with SCL high is stop; returns to standby.
// - 8-bit words; device acknowledges low in the ninth clock.
// - standby at power-up and after stop once programming ends.
// - nine clocks with SDA high then start and stop resynchronise.
// - device address word carries fixed upper four-bit pattern.
// - address word LSB one reads, zero writes.
// - matching address acknowledged; mismatch not acknowledged, back to standby.
// - write-protect high blocks programming of the whole array.
// - byte write: address, word address, data, then stop starts programming.
// - programming takes 3 ms and all bus inputs are ignored.
// - page write accepts up to 16 bytes, each acknowledged.
// - write advances only low four address bits, wrapping in page.
// - polling address acknowledged only once programming has finished.
// - address counter keeps last address plus one between operations.
// - read address wraps from last byte to first byte.
// - current read shifts out byte at counter after acknowledge.
// - controller acknowledge continues sequential read; no acknowledge ends it.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_params.svh"

module i2c_serial_eeprom_slave
  import eeprom_types_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic wp,
  output logic program_busy,
  output logic standby
);

  // =====================================================
  // declarations
  logic [7:0] mem_r [0:`MEM_BYTES-1];
  logic [7:0] page_buf_r [0:`PAGE_BYTES-1];
  link_state_type state_r;
  link_state_type state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] shift_r;
  logic ack_r;
  logic rd_r;
  logic pend_r;
  logic pend_nxt;
  logic [`PAGE_BYTES-1:0] mask_r;
  logic [`ADDR_W-1:0] addr_r;
  logic [`ADDR_W-1:0] addr_nxt;
  logic sda_oe_r;
  logic link_hold_r;
  logic hold_r;
  logic hold_nxt;
  logic [1:0] rs_cnt_r;
  logic [1:0] rs_cnt_nxt;
  logic busy_r;
  logic [`PROG_CNT_W-1:0] prog_cnt_r;
  logic standby_r;
  sync_type meta_r;
  sync_type sync_r;
  sync_type prev_r;
  sync_type raw_in;

  wire link_rst_n;
  wire [7:0] byte_in;
  wire dev_word_type dev_word;
  wire byte_done;
  wire ack_slot;
  wire dev_match;
  wire in_dev;
  wire in_waddr;
  wire in_wdata;
  wire in_rdata;
  wire ack_nxt;
  wire [7:0] rd_byte;
  wire [2:0] bit_sel;
  wire tx_bit;
  wire drive_nxt;
  wire start_det;
  wire stop_det;
  wire launch;
  wire prog_last;

  // =====================================================
  // link side: bit framing on the serial clock
  // held in reset between frames and during programming, so it
  // never counts on an edge outside a frame
  assign link_rst_n = rst_n & ~link_hold_r;

  assign byte_in = {shift_r[6:0], sda_i};
  assign dev_word = dev_word_type'(byte_in);
  assign byte_done = (cnt_r == `BIT_LAST);
  assign ack_slot = (cnt_r == `BIT_ACK);
  assign dev_match = (dev_word.pattern == `DEV_PATTERN);
  assign in_dev = (state_r == ST_DEV);
  assign in_waddr = (state_r == ST_WADDR);
  assign in_wdata = (state_r == ST_WDATA);
  assign in_rdata = (state_r == ST_RDATA);
  assign cnt_nxt = ack_slot ? 4'h0 : cnt_r + 4'h1;

  // acknowledge every received word that is ours
  assign ack_nxt = byte_done & ((in_dev & dev_match) | in_waddr | in_wdata);

  // pending program: set after the data acknowledge clock,
  // dropped once a second bit of a further byte arrives
  assign pend_nxt = (in_wdata & ack_slot) ? 1'b1 :
                    (in_wdata & (cnt_r == `BIT_SECOND)) ? 1'b0 : pend_r;

  // next protocol state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_DEV: begin
        if (byte_done && !dev_match) begin
          state_nxt = ST_IGNORE;
        end else if (ack_slot) begin
          state_nxt = rd_r ? ST_RDATA : ST_WADDR;
        end
      end
      ST_WADDR: begin
        if (ack_slot) begin
          state_nxt = ST_WDATA;
        end
      end
      ST_WDATA: begin
        state_nxt = ST_WDATA;
      end
      ST_RDATA: begin
        if (ack_slot && sda_i) begin
          state_nxt = ST_IGNORE;
        end
      end
      ST_IGNORE: begin
        state_nxt = ST_IGNORE;
      end
      default: begin
        state_nxt = ST_IGNORE;
      end
    endcase
  end

  // address counter update per completed word
  always_comb begin
    addr_nxt = addr_r;
    if (byte_done) begin
      if (in_dev && dev_match) begin
        addr_nxt = {dev_word.blk, addr_r[7:0]};
      end else if (in_waddr) begin
        addr_nxt = {addr_r[10:8], byte_in};
      end else if (in_wdata) begin
        addr_nxt = {addr_r[10:4], addr_r[3:0] + 4'h1};
      end else if (in_rdata) begin
        addr_nxt = addr_r + 11'h001;
      end
    end
  end

  // protocol registers, cleared by every frame reset
  always_ff @(posedge serial_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_r <= ST_DEV;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ack_r <= 1'b0;
      rd_r <= 1'b0;
      pend_r <= 1'b0;
      mask_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= byte_in;
      ack_r <= ack_nxt;
      pend_r <= pend_nxt;
      if (in_dev && byte_done) begin
        rd_r <= dev_word.rd;
      end
      if (in_wdata && byte_done) begin
        mask_r[addr_r[3:0]] <= 1'b1;
      end
    end
  end

  // page buffer, overwritten on wrap within the page
  always_ff @(posedge serial_clk) begin
    if (in_wdata && byte_done) begin
      page_buf_r[addr_r[3:0]] <= byte_in;
    end
  end

  // address counter survives frames; only power-on clears it
  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= 11'h000;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  // =====================================================
  // link side: open-drain output, changed on the falling edge
  assign rd_byte = mem_r[addr_r];
  assign bit_sel = ~cnt_r[2:0];
  assign tx_bit = rd_byte[bit_sel];
  assign drive_nxt = (ack_slot & ack_r) | (in_rdata & ~ack_slot & ~tx_bit);

  always_ff @(negedge serial_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_oe_r <= 1'b0;
    end else begin
      sda_oe_r <= drive_nxt;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_r;

  // =====================================================
  // system side: pin synchronisers
  assign raw_in = '{pend: pend_r, wp: wp, sda: sda_i, scl: serial_clk};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 4'hF;
      sync_r <= 4'hF;
      prev_r <= 4'hF;
    end else begin
      meta_r <= raw_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // start and stop seen as SDA edges while SCL stays high
  assign start_det = sync_r.scl & prev_r.scl & prev_r.sda & ~sync_r.sda;
  assign stop_det = sync_r.scl & prev_r.scl & ~prev_r.sda & sync_r.sda;

  // program only for a finished, acknowledged, unprotected write
  assign launch = stop_det & sync_r.pend & ~busy_r & ~sync_r.wp;
  assign prog_last = (prog_cnt_r == `PROG_CNT_W'(PROG_CYCLES - 1));

  // frame hold: set by stop, released by a start when idle
  assign hold_nxt = stop_det ? 1'b1 :
                    (start_det & ~busy_r) ? 1'b0 : hold_r;
  assign rs_cnt_nxt = (start_det & ~busy_r) ? `RS_PULSE_CYCLES :
                      (rs_cnt_r != 2'h0) ? rs_cnt_r - 2'h1 : 2'h0;

  // frame control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= 1'b1;
      rs_cnt_r <= 2'h0;
      link_hold_r <= 1'b1;
    end else begin
      hold_r <= hold_nxt;
      rs_cnt_r <= rs_cnt_nxt;
      link_hold_r <= hold_nxt | busy_r | launch | (rs_cnt_nxt != 2'h0);
    end
  end

  // internally timed programming cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      prog_cnt_r <= '0;
    end else if (launch) begin
      busy_r <= 1'b1;
      prog_cnt_r <= '0;
    end else if (busy_r) begin
      busy_r <= ~prog_last;
      prog_cnt_r <= prog_cnt_r + `PROG_CNT_W'(1);
    end
  end

  // page copy into the array; the link is idle and held after
  // stop, so the buffer and mask are stable when read here
  always_ff @(posedge sys_clk) begin
    if (launch) begin
      for (int i = 0; i < `PAGE_BYTES; i++) begin
        if (mask_r[i]) begin
          mem_r[{addr_r[10:4], 4'(i)}] <= page_buf_r[i];
        end
      end
    end
  end

  // standby: no frame open and no programming under way
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      standby_r <= 1'b1;
    end else begin
      standby_r <= hold_nxt & ~busy_r & ~launch;
    end
  end

  assign program_busy = busy_r;
  assign standby = standby_r;

  // =====================================================
  // checks
  AST_ACK_LOW: assert property (@(posedge serial_clk) disable iff (!link_rst_n)
    (byte_done && ack_nxt) |=> sda_oe_r && ack_slot)
    else $error("acknowledge not driven in ninth clock");

  AST_MISMATCH: assert property (@(posedge serial_clk) disable iff (!link_rst_n)
    (in_dev && byte_done && !dev_match) |=> (state_r == ST_IGNORE) && !ack_r ##1 !sda_oe_r)
    else $error("foreign address was answered");

  AST_PAGE_WRAP: assert property (@(posedge serial_clk) disable iff (!link_rst_n)
    (in_wdata && byte_done) |=>
      (addr_r[10:4] == $past(addr_r[10:4])) && (addr_r[3:0] == $past(addr_r[3:0]) + 4'h1))
    else $error("write address left its page");

  AST_READ_INC: assert property (@(posedge serial_clk) disable iff (!link_rst_n)
    (in_rdata && byte_done) |=> addr_r == $past(addr_r) + 11'h001)
    else $error("read address did not advance");

  AST_NACK_END: assert property (@(posedge serial_clk) disable iff (!link_rst_n)
    (in_rdata && ack_slot && sda_i) |=> (state_r == ST_IGNORE) ##1 !sda_oe_r[*2])
    else $error("read went on after missing acknowledge");

  AST_LAUNCH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (stop_det && sync_r.pend && !sync_r.wp && !busy_r) |=> busy_r && link_hold_r)
    else $error("stop after data did not start programming");

  AST_PROTECT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (stop_det && sync_r.wp && !busy_r) |=> !busy_r)
    else $error("protected write started programming");

  AST_ABORT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (stop_det && !sync_r.pend) |=> !$rose(busy_r))
    else $error("programming without a finished byte");

  AST_IGNORE_BUS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busy_r |-> link_hold_r && !sda_oe)
    else $error("bus answered during programming");

  AST_PROG_END: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (busy_r && prog_last) |=> !busy_r ##1 !busy_r)
    else $error("programming length wrong");

  AST_START_OPEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (start_det && !busy_r) |=> link_hold_r [*3] ##1 !link_hold_r)
    else $error("start did not open a frame");

  AST_RW_SELECT: assert property (@(posedge serial_clk) disable iff (!link_rst_n)
    (in_dev && byte_done && dev_match) |=> rd_r == $past(dev_word.rd))
    else $error("read or write not taken from address word");

  AST_BLOCK_BITS: assert property (@(posedge serial_clk) disable iff (!link_rst_n)
    (in_dev && byte_done && dev_match) |=> addr_r[10:8] == $past(dev_word.blk))
    else $error("upper address bits not taken from address word");

  AST_IDLE_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    standby |-> link_hold_r && !sda_oe)
    else $error("link active during standby");

  AST_STOP_CLOSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stop_det |=> hold_r && link_hold_r)
    else $error("stop did not close the frame");

endmodule

`default_nettype wire

// ===== dv/ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module ctrl_model (
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  // ==========================================
  // two-wire controller, open drain data
  // clock and data rest high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // one bit: data moves with clock low, sampled late in high
  task automatic bit_x(input logic b, output logic s);
    // the previous bit already left the clock low
    if (scl !== 1'b0) begin
      scl = 1'b0;
    end
    #7 sda_low = ~b;
    #8 scl = 1'b1;
    #14 s = sda_in;
    #1 scl = 1'b0;
  endtask

  // start or repeated start, slow edges so the sync sees them
  task automatic start();
    sda_low = 1'b0;
    #50 scl = 1'b1;
    #100 sda_low = 1'b1;
    #100 scl = 1'b0;
    #100;
  endtask

  // stop ends every frame
  task automatic stop();
    if (scl !== 1'b0) begin
      scl = 1'b0;
    end
    sda_low = 1'b1;
    #100 scl = 1'b1;
    #100 sda_low = 1'b0;
    #100;
  endtask

  // byte out msb first, ninth bit released for the ack
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], s);
    end
    bit_x(1'b1, s);
    ack = ~s;
  endtask

  // byte in, then ack to continue or release to end
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(~ack, s);
  endtask

  // nine clocks with data high, then start and stop
  task automatic recover();
    logic s;
    repeat (9) bit_x(1'b1, s);
    start();
    stop();
  endtask
endmodule

`default_nettype wire

// ===== dv/test_i2c_serial_eeprom_slave.sv
`timescale 1ns/1ps
`default_nettype none

module test_i2c_serial_eeprom_slave;
  localparam int unsigned PROG = 200;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp = 1'b0;
  logic scl;
  logic ctrl_low;
  logic sda_o;
  logic sda_oe;
  logic program_busy;
  logic standby;
  logic ack;
  logic [7:0] d;
  int failures = 0;
  int comparisons = 0;
  // data wire: low if either side pulls, pull-up otherwise
  wire sda_wire = ~((sda_oe & ~sda_o) | ctrl_low);

  // ==========================================
  // clock, device and controller
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  i2c_serial_eeprom_slave #(.PROG_CYCLES(PROG)) i2c_serial_eeprom_slave_inst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .serial_clk(scl),
    .sda_i(sda_wire),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .wp(wp),
    .program_busy(program_busy),
    .standby(standby)
  );

  ctrl_model ctrl_model_inst (
    .sda_in(sda_wire),
    .scl(scl),
    .sda_low(ctrl_low)
  );

  // ==========================================
  // helpers
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // bounded wait for the end of programming
  task automatic wait_idle();
    int n;
    n = 0;
    while (program_busy !== 1'b0 && n < PROG + 100) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= PROG + 100) begin
      failures++;
      finish_test();
    end
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic send(input logic [7:0] v, input logic e);
    ctrl_model_inst.wr_byte(v, ack);
    check("ack", {7'h00, e}, {7'h00, ack});
  endtask

  task automatic get(input logic a, input logic [7:0] e);
    ctrl_model_inst.rd_byte(a, d);
    check("data", e, d);
  endtask

  // write n bytes v, v+1.. at a, poll once while programming
  task automatic write(input logic [10:0] a, input logic [7:0] v, input int n, input logic bsy);
    ctrl_model_inst.start();
    send({4'hA, a[10:8], 1'b0}, 1'b1);
    send(a[7:0], 1'b1);
    for (int i = 0; i < n; i++) begin
      send(v + 8'(i), 1'b1);
    end
    ctrl_model_inst.stop();
    repeat (10) @(posedge sys_clk);
    check("busy", {7'h00, bsy}, {7'h00, program_busy});
    ctrl_model_inst.start();
    send({4'hA, a[10:8], 1'b0}, ~bsy);
    ctrl_model_inst.stop();
    wait_idle();
    check("standby", 8'h01, {7'h00, standby});
  endtask

  // dummy write then repeated start with read word
  task automatic rd_open(input logic [10:0] a);
    ctrl_model_inst.start();
    send({4'hA, a[10:8], 1'b0}, 1'b1);
    send(a[7:0], 1'b1);
    ctrl_model_inst.start();
    send({4'hA, a[10:8], 1'b1}, 1'b1);
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    repeat (20) @(posedge sys_clk);
    check("standby", 8'h01, {7'h00, standby});
    check("busy", 8'h00, {7'h00, program_busy});
    check("oe", 8'h00, {7'h00, sda_oe});
    check("sda_o", 8'h00, {7'h00, sda_o});
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic t_write_read();
    write(11'h3F5, 8'h5A, 1, 1'b1);
    write(11'h000, 8'h10, 2, 1'b1);
    write(11'h7FF, 8'hC3, 1, 1'b1);
    rd_open(11'h7FF);
    get(1'b1, 8'hC3);
    get(1'b0, 8'h10);
    ctrl_model_inst.stop();
    repeat (8) @(posedge sys_clk);
    check("standby", 8'h01, {7'h00, standby});
    ctrl_model_inst.start();
    send(8'hA1, 1'b1);
    get(1'b0, 8'h11);
    ctrl_model_inst.stop();
  endtask

  task automatic t_page();
    write(11'h12E, 8'h40, 18, 1'b1);
    rd_open(11'h120);
    for (int o = 0; o < 16; o++) begin
      get(o < 15, o < 14 ? 8'h42 + 8'(o) : 8'h50 + 8'(o - 14));
    end
    ctrl_model_inst.stop();
  endtask

  task automatic t_protect();
    @(posedge sys_clk);
    wp <= 1'b1;
    write(11'h7FF, 8'h99, 1, 1'b0);
    @(posedge sys_clk);
    wp <= 1'b0;
    rd_open(11'h7FF);
    get(1'b0, 8'hC3);
    ctrl_model_inst.stop();
  endtask

  task automatic t_mismatch();
    ctrl_model_inst.start();
    send(8'h50, 1'b0);
    ctrl_model_inst.stop();
    repeat (8) @(posedge sys_clk);
    check("standby", 8'h01, {7'h00, standby});
  endtask

  task automatic t_abort();
    logic s;
    ctrl_model_inst.start();
    send(8'hA0, 1'b1);
    send(8'h05, 1'b1);
    repeat (4) ctrl_model_inst.bit_x(1'b1, s);
    ctrl_model_inst.stop();
    repeat (10) @(posedge sys_clk);
    check("busy", 8'h00, {7'h00, program_busy});
    ctrl_model_inst.recover();
    rd_open(11'h3F5);
    get(1'b0, 8'h5A);
    ctrl_model_inst.stop();
  endtask

  // main sequence
  initial begin
    t_reset();
    t_write_read();
    t_page();
    t_protect();
    t_mismatch();
    t_abort();
    finish_test();
  end
endmodule

`default_nettype wire
